// >>> design/tad_regs.svh
// constants for the transfer and arithmetic opcode decoder
`ifndef TAD_REGS_SVH
`define TAD_REGS_SVH

`define TAD_OP_SEG_FROM_RM 8'h8E
`define TAD_OP_SEG_TO_RM 8'h8C
`define TAD_OP_TABLE_XLT 8'hD7
`define TAD_OP_LOAD_EA 8'h8D
`define TAD_OP_FAR_DATA 8'hC5
`define TAD_OP_FAR_EXTRA 8'hC4
`define TAD_OP_HIGH_FROM_FLAGS 8'h9F
`define TAD_OP_FLAGS_FROM_HIGH 8'h9E
`define TAD_OP_ASCII_ADD 8'h37
`define TAD_OP_DECIMAL_ADD 8'h27
`define TAD_OP_ASCII_SUB 8'h3F
`define TAD_OP_DECIMAL_SUB 8'h2F
`define TAD_OP_ASCII_PRODUCT 8'hD4
`define TAD_OP_ASCII_DIV 8'hD5
`define TAD_OP_ASCII_BASE 8'h0A
`define TAD_OP_BYTE_TO_WORD 8'h98
`define TAD_OP_WORD_TO_DOUBLE 8'h99
// upper six bits of the d/w forms
`define TAD_PFX_ADD 6'h00
`define TAD_PFX_ADC 6'h04
`define TAD_PFX_SUB 6'h0A
`define TAD_PFX_SBB 6'h06
// upper seven bits of the w forms
`define TAD_PFX_ADC_ACC_IMM 7'h0A
`define TAD_PFX_GROUP3 7'h7B
// upper six bits of the s/w immediate group
`define TAD_PFX_IMM_GROUP 6'h20
// middle field codes
`define TAD_MID_UPRODUCT 3'h4
`define TAD_MID_SPRODUCT 3'h5
`define TAD_MID_DIV 3'h6
`define TAD_MID_SQUOTIENT 3'h7
`define TAD_MID_ADD 3'h0
`define TAD_MID_ADC 3'h2
`define TAD_MID_SBB 3'h3
`define TAD_MID_SUB 3'h5
`define TAD_MOD_REG 2'h3
`define TAD_RM_DIRECT 3'h6

`endif

// >>> design/tad_pkg.sv
// types shared by the opcode decoder files
package tad_pkg;
	typedef enum logic [4:0] {
		TAD_OP_NONE,
		TAD_OP_SEG_FROM_RM,
		TAD_OP_SEG_TO_RM,
		TAD_OP_TABLE_TRANSLATE_BYTE,
		TAD_OP_LOAD_EFFECTIVE_ADDRESS,
		TAD_OP_FAR_POINTER_LOAD_DATA_SEG,
		TAD_OP_FAR_POINTER_LOAD_EXTRA_SEG,
		TAD_OP_HIGH_ACCUM_FROM_FLAGS,
		TAD_OP_FLAGS_FROM_HIGH_ACCUM,
		TAD_OP_ADD,
		TAD_OP_ADD_WITH_CARRY,
		TAD_OP_SUBTRACT,
		TAD_OP_SUBTRACT_WITH_BORROW,
		TAD_OP_ADD_WITH_CARRY_IMM_ACC,
		TAD_OP_ADD_IMM_RM,
		TAD_OP_ADD_WITH_CARRY_IMM_RM,
		TAD_OP_SUBTRACT_IMM_RM,
		TAD_OP_SUBTRACT_WITH_BORROW_IMM_RM,
		TAD_OP_ASCII_ADJUST_ADD,
		TAD_OP_DECIMAL_ADJUST_ADD,
		TAD_OP_ASCII_ADJUST_SUBTRACT,
		TAD_OP_DECIMAL_ADJUST_SUBTRACT,
		TAD_OP_UNSIGNED_PRODUCT,
		TAD_OP_SIGNED_PRODUCT,
		TAD_OP_UNSIGNED_QUOTIENT,
		TAD_OP_SIGNED_QUOTIENT,
		TAD_OP_ASCII_ADJUST_MULTIPLY,
		TAD_OP_ASCII_ADJUST_DIVIDE,
		TAD_OP_BYTE_TO_WORD_EXTEND,
		TAD_OP_WORD_TO_DOUBLE_EXTEND,
		TAD_OP_INVALID
	} tad_op_e;

	// what follows the opcode byte
	typedef enum logic [1:0] {
		TAD_FOLLOW_NONE,
		TAD_FOLLOW_MODRM,
		TAD_FOLLOW_FIXED,
		TAD_FOLLOW_IMM
	} tad_follow_e;

	typedef struct packed {
		tad_op_e op;
		tad_follow_e follow;
		logic [2:0] need_mid;
		logic check_mid;
		logic check_mid_seg;
		logic dir_to_reg;
		logic word;
		logic sign_ext_imm;
		logic [1:0] imm_bytes;
	} tad_class_s;
endpackage : tad_pkg

// >>> design/tad_cls_if.sv
// carries the first-byte classification between the decoder's modules
interface tad_cls_if;
	logic [7:0] opcode;
	tad_pkg::tad_class_s cls;
	modport classifier (input opcode, output cls);
	modport user (output opcode, input cls);
endinterface : tad_cls_if

// >>> design/tad_first_byte.sv
// combinational classification of an opcode byte
`include "tad_regs.svh"
module tad_first_byte (
	tad_cls_if.classifier bus
);
	logic [7:0] b;
	assign b = bus.opcode;

	always_comb begin
		bus.cls = '0;
		bus.cls.op = tad_pkg::TAD_OP_INVALID;
		bus.cls.follow = tad_pkg::TAD_FOLLOW_NONE;
		bus.cls.word = b[0];
		bus.cls.dir_to_reg = b[1];
		if (b == `TAD_OP_SEG_FROM_RM) begin
			bus.cls.op = tad_pkg::TAD_OP_SEG_FROM_RM;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.check_mid_seg = 1'b1;
			bus.cls.dir_to_reg = 1'b1;
			bus.cls.word = 1'b1;
		end else if (b == `TAD_OP_SEG_TO_RM) begin
			bus.cls.op = tad_pkg::TAD_OP_SEG_TO_RM;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.check_mid_seg = 1'b1;
			bus.cls.dir_to_reg = 1'b0;
			bus.cls.word = 1'b1;
		end else if (b == `TAD_OP_TABLE_XLT) begin
			bus.cls.op = tad_pkg::TAD_OP_TABLE_TRANSLATE_BYTE;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_LOAD_EA) begin
			bus.cls.op = tad_pkg::TAD_OP_LOAD_EFFECTIVE_ADDRESS;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.dir_to_reg = 1'b1;
			bus.cls.word = 1'b1;
		end else if (b == `TAD_OP_FAR_DATA) begin
			bus.cls.op = tad_pkg::TAD_OP_FAR_POINTER_LOAD_DATA_SEG;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.dir_to_reg = 1'b1;
			bus.cls.word = 1'b1;
		end else if (b == `TAD_OP_FAR_EXTRA) begin
			bus.cls.op = tad_pkg::TAD_OP_FAR_POINTER_LOAD_EXTRA_SEG;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.dir_to_reg = 1'b1;
			bus.cls.word = 1'b1;
		end else if (b == `TAD_OP_HIGH_FROM_FLAGS) begin
			bus.cls.op = tad_pkg::TAD_OP_HIGH_ACCUM_FROM_FLAGS;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_FLAGS_FROM_HIGH) begin
			bus.cls.op = tad_pkg::TAD_OP_FLAGS_FROM_HIGH_ACCUM;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_ASCII_ADD) begin
			bus.cls.op = tad_pkg::TAD_OP_ASCII_ADJUST_ADD;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_DECIMAL_ADD) begin
			bus.cls.op = tad_pkg::TAD_OP_DECIMAL_ADJUST_ADD;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_ASCII_SUB) begin
			bus.cls.op = tad_pkg::TAD_OP_ASCII_ADJUST_SUBTRACT;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_DECIMAL_SUB) begin
			bus.cls.op = tad_pkg::TAD_OP_DECIMAL_ADJUST_SUBTRACT;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_ASCII_PRODUCT) begin
			bus.cls.op = tad_pkg::TAD_OP_ASCII_ADJUST_MULTIPLY;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_FIXED;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_ASCII_DIV) begin
			bus.cls.op = tad_pkg::TAD_OP_ASCII_ADJUST_DIVIDE;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_FIXED;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_BYTE_TO_WORD) begin
			bus.cls.op = tad_pkg::TAD_OP_BYTE_TO_WORD_EXTEND;
			bus.cls.word = 1'b0;
		end else if (b == `TAD_OP_WORD_TO_DOUBLE) begin
			bus.cls.op = tad_pkg::TAD_OP_WORD_TO_DOUBLE_EXTEND;
			bus.cls.word = 1'b1;
		end else if (b[7:2] == `TAD_PFX_ADD) begin
			bus.cls.op = tad_pkg::TAD_OP_ADD;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
		end else if (b[7:2] == `TAD_PFX_ADC) begin
			bus.cls.op = tad_pkg::TAD_OP_ADD_WITH_CARRY;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
		end else if (b[7:2] == `TAD_PFX_SUB) begin
			bus.cls.op = tad_pkg::TAD_OP_SUBTRACT;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
		end else if (b[7:2] == `TAD_PFX_SBB) begin
			bus.cls.op = tad_pkg::TAD_OP_SUBTRACT_WITH_BORROW;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
		end else if (b[7:1] == `TAD_PFX_ADC_ACC_IMM) begin
			bus.cls.op = tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_ACC;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_IMM;
			bus.cls.imm_bytes = b[0] ? 2'd2 : 2'd1;
		end else if (b[7:1] == `TAD_PFX_GROUP3) begin
			// operation chosen by the middle field of the next byte
			bus.cls.op = tad_pkg::TAD_OP_NONE;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.check_mid = 1'b1;
		end else if (b[7:2] == `TAD_PFX_IMM_GROUP) begin
			bus.cls.op = tad_pkg::TAD_OP_NONE;
			bus.cls.follow = tad_pkg::TAD_FOLLOW_MODRM;
			bus.cls.check_mid = 1'b1;
			bus.cls.dir_to_reg = 1'b0;
			bus.cls.sign_ext_imm = b[1];
			bus.cls.imm_bytes = (!b[1] && b[0]) ? 2'd2 : 2'd1;
		end
	end
endmodule : tad_first_byte

// >>> design/tad_disp_count.sv
// displacement byte count implied by mod and rm
`include "tad_regs.svh"
module tad_disp_count (
	input wire logic [7:0] modrm_in,
	output logic [1:0] disp_bytes_out
);
	always_comb begin
		if (modrm_in[7:6] == 2'h0) begin
			disp_bytes_out = (modrm_in[2:0] == `TAD_RM_DIRECT) ? 2'd2 : 2'd0;
		end else if (modrm_in[7:6] == `TAD_MOD_REG) begin
			disp_bytes_out = 2'd0;
		end else begin
			disp_bytes_out = modrm_in[7:6];
		end
	end
endmodule : tad_disp_count

// >>> design/tad_decoder.sv
// transfer and arithmetic opcode decoder with byte stream sequencing
`include "tad_regs.svh"
module tad_decoder (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	output logic byte_ready_out,
	output logic done_out,
	output tad_pkg::tad_op_e op_out,
	output logic word_out,
	output logic dir_to_reg_out,
	output logic [1:0] mod_out,
	output logic [2:0] reg_out,
	output logic [2:0] rm_out,
	output logic [15:0] disp_out,
	output logic [15:0] imm_out,
	output logic invalid_out
);
	typedef enum logic [2:0] {
		TAD_ST_OPCODE,
		TAD_ST_MODRM,
		TAD_ST_FIXED,
		TAD_ST_DISP,
		TAD_ST_IMM
	} tad_state_e;

	tad_state_e state;
	tad_state_e next_state;
	tad_pkg::tad_class_s cls;
	tad_pkg::tad_class_s next_cls;
	logic [7:0] modrm;
	logic [7:0] next_modrm;
	logic [1:0] disp_left;
	logic [1:0] next_disp_left;
	logic [1:0] disp_got;
	logic [1:0] next_disp_got;
	logic [1:0] imm_left;
	logic [1:0] next_imm_left;
	logic [1:0] imm_got;
	logic [1:0] next_imm_got;
	logic [15:0] disp;
	logic [15:0] next_disp;
	logic [15:0] imm;
	logic [15:0] next_imm;
	logic done;
	logic next_done;
	tad_pkg::tad_op_e op;
	tad_pkg::tad_op_e next_op;
	logic invalid;
	logic next_invalid;
	logic [1:0] disp_need;
	logic take;

	tad_cls_if cls_bus ();
	assign cls_bus.opcode = byte_in;

	tad_first_byte u_first (
		.bus(cls_bus)
	);

	tad_disp_count u_disp (
		.modrm_in(byte_in),
		.disp_bytes_out(disp_need)
	);

	// middle-field selection for the grouped opcodes
	function automatic tad_pkg::tad_op_e group_op(input logic imm_group, input logic [2:0] mid);
		tad_pkg::tad_op_e r;
		r = tad_pkg::TAD_OP_INVALID;
		if (!imm_group) begin
			if (mid == `TAD_MID_UPRODUCT) begin
				r = tad_pkg::TAD_OP_UNSIGNED_PRODUCT;
			end else if (mid == `TAD_MID_SPRODUCT) begin
				r = tad_pkg::TAD_OP_SIGNED_PRODUCT;
			end else if (mid == `TAD_MID_DIV) begin
				r = tad_pkg::TAD_OP_UNSIGNED_QUOTIENT;
			end else if (mid == `TAD_MID_SQUOTIENT) begin
				r = tad_pkg::TAD_OP_SIGNED_QUOTIENT;
			end
		end else begin
			if (mid == `TAD_MID_ADD) begin
				r = tad_pkg::TAD_OP_ADD_IMM_RM;
			end else if (mid == `TAD_MID_ADC) begin
				r = tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_RM;
			end else if (mid == `TAD_MID_SUB) begin
				r = tad_pkg::TAD_OP_SUBTRACT_IMM_RM;
			end else if (mid == `TAD_MID_SBB) begin
				r = tad_pkg::TAD_OP_SUBTRACT_WITH_BORROW_IMM_RM;
			end
		end
		return r;
	endfunction : group_op

	// sign or zero extension of a lone immediate byte, chosen by sx
	function automatic logic [15:0] imm_finish(input logic [15:0] v, input logic sx,
		input logic two);
		logic [15:0] r;
		r = v;
		if (!two) begin
			r = sx ? {{8{v[7]}}, v[7:0]} : {8'h00, v[7:0]};
		end
		return r;
	endfunction : imm_finish

	// the stream never stalls; ready is held high in every cycle, including the one that shows the result
	assign take = byte_valid_in && byte_ready_out;
	assign byte_ready_out = 1'b1;

	always_comb begin
		next_state = state;
		next_cls = cls;
		next_modrm = modrm;
		next_disp_left = disp_left;
		next_disp_got = disp_got;
		next_imm_left = imm_left;
		next_imm_got = imm_got;
		next_disp = disp;
		next_imm = imm;
		next_op = op;
		next_invalid = invalid;
		next_done = 1'b0;
		if (take) begin
			case (state)
				TAD_ST_OPCODE: begin
					next_cls = cls_bus.cls;
					next_op = cls_bus.cls.op;
					next_invalid = 1'b0;
					next_modrm = 8'h00;
					next_disp = 16'h0000;
					next_imm = 16'h0000;
					next_disp_got = 2'd0;
					next_imm_got = 2'd0;
					next_imm_left = cls_bus.cls.imm_bytes;
					case (cls_bus.cls.follow)
						tad_pkg::TAD_FOLLOW_MODRM: next_state = TAD_ST_MODRM;
						tad_pkg::TAD_FOLLOW_FIXED: next_state = TAD_ST_FIXED;
						tad_pkg::TAD_FOLLOW_IMM: next_state = TAD_ST_IMM;
						default: begin
							next_done = 1'b1;
							next_invalid = (cls_bus.cls.op == tad_pkg::TAD_OP_INVALID);
						end
					endcase
				end
				TAD_ST_FIXED: begin
					// second byte must be the fixed base value
					if (byte_in != `TAD_OP_ASCII_BASE) begin
						next_op = tad_pkg::TAD_OP_INVALID;
						next_invalid = 1'b1;
					end
					next_done = 1'b1;
					next_state = TAD_ST_OPCODE;
				end
				TAD_ST_MODRM: begin
					next_modrm = byte_in;
					next_disp_left = disp_need;
					if (cls.check_mid) begin
						next_op = group_op(cls.imm_bytes != 2'd0, byte_in[5:3]);
					end
					if (cls.check_mid_seg && byte_in[5]) begin
						// the selector field holds only two segment bits
						next_op = tad_pkg::TAD_OP_INVALID;
					end
					if (disp_need != 2'd0) begin
						next_state = TAD_ST_DISP;
					end else if (cls.imm_bytes != 2'd0) begin
						next_state = TAD_ST_IMM;
					end else begin
						next_done = 1'b1;
						next_state = TAD_ST_OPCODE;
					end
					next_invalid = cls.check_mid || (cls.check_mid_seg && byte_in[5]) ?
						(next_op == tad_pkg::TAD_OP_INVALID) : 1'b0;
				end
				TAD_ST_DISP: begin
					if (disp_got == 2'd0) begin
						next_disp = {{8{byte_in[7]}}, byte_in};
					end else begin
						next_disp = {byte_in, disp[7:0]};
					end
					next_disp_got = disp_got + 2'd1;
					next_disp_left = disp_left - 2'd1;
					if (disp_left == 2'd1) begin
						if (cls.imm_bytes != 2'd0) begin
							next_state = TAD_ST_IMM;
						end else begin
							next_done = 1'b1;
							next_state = TAD_ST_OPCODE;
						end
					end
				end
				TAD_ST_IMM: begin
					if (imm_got == 2'd0) begin
						next_imm = imm_finish({8'h00, byte_in}, cls.sign_ext_imm, 1'b0);
					end else begin
						next_imm = {byte_in, imm[7:0]};
					end
					next_imm_got = imm_got + 2'd1;
					next_imm_left = imm_left - 2'd1;
					if (imm_left == 2'd1) begin
						next_done = 1'b1;
						next_state = TAD_ST_OPCODE;
					end
				end
				default: next_state = TAD_ST_OPCODE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state <= TAD_ST_OPCODE;
			cls <= '0;
			modrm <= 8'h00;
			disp_left <= 2'd0;
			disp_got <= 2'd0;
			imm_left <= 2'd0;
			imm_got <= 2'd0;
			disp <= 16'h0000;
			imm <= 16'h0000;
			done <= 1'b0;
			op <= tad_pkg::TAD_OP_NONE;
			invalid <= 1'b0;
		end else begin
			state <= next_state;
			cls <= next_cls;
			modrm <= next_modrm;
			disp_left <= next_disp_left;
			disp_got <= next_disp_got;
			imm_left <= next_imm_left;
			imm_got <= next_imm_got;
			disp <= next_disp;
			imm <= next_imm;
			done <= next_done;
			op <= next_op;
			invalid <= next_invalid;
		end
	end

	assign done_out = done;
	assign op_out = op;
	assign invalid_out = invalid;
	assign word_out = cls.word;
	assign dir_to_reg_out = cls.dir_to_reg;
	assign mod_out = modrm[7:6];
	assign reg_out = modrm[5:3];
	assign rm_out = modrm[2:0];
	assign disp_out = disp;
	assign imm_out = imm;
endmodule : tad_decoder

// >>> tb/tad_fetch_model.sv
// fetch-side model that offers instruction bytes to the decoder
module tad_fetch_model (
	input wire logic clk_in,
	output logic byte_valid_out,
	output logic [7:0] byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last = 8'h00;

	initial begin
		byte_valid_out = 1'b0;
		byte_out = 8'hFF;
	end

	// idle cycles toggle the byte so a stale value can never be taken for a fresh one
	task automatic idle();
		@(posedge clk_in);
		last = ~last;
		byte_valid_out <= 1'b0;
		byte_out <= last;
	endtask : idle

	// the byte is taken at the next edge; gap inserts idle cycles before it
	task automatic put(input logic [7:0] b, input int gap);
		repeat (gap) idle();
		@(posedge clk_in);
		last = b;
		byte_valid_out <= 1'b1;
		byte_out <= b;
	endtask : put
endmodule : tad_fetch_model

// >>> tb/tad_decoder_assertions.sv
// concurrent checks on the opcode decoder ports
module tad_decoder_assertions (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic byte_ready_out,
	input wire logic done_out,
	input wire tad_pkg::tad_op_e op_out,
	input wire logic word_out,
	input wire logic dir_to_reg_out,
	input wire logic [1:0] mod_out,
	input wire logic [2:0] reg_out,
	input wire logic [2:0] rm_out,
	input wire logic [15:0] imm_out,
	input wire logic invalid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// opcode boundary tracking
	// ------------------------------
	logic pend_q;
	logic next_pend;
	logic at_op;
	logic [7:0] first_q;
	logic [7:0] next_first;

	// a finished instruction means the next byte taken is an opcode
	assign at_op = pend_q | done_out;

	always_comb begin
		next_pend = at_op & ~byte_valid_in;
		next_first = (at_op && byte_valid_in) ? byte_in : first_q;
		if (!reset_n_in) begin
			next_pend = 1'b1;
			next_first = 8'h00;
		end
	end

	always_ff @(posedge clk_in) begin
		pend_q <= next_pend;
		first_q <= next_first;
	end

	function automatic tad_pkg::tad_op_e single_op(input logic [7:0] b);
		case (b)
			8'hD7: return tad_pkg::TAD_OP_TABLE_TRANSLATE_BYTE;
			8'h9F: return tad_pkg::TAD_OP_HIGH_ACCUM_FROM_FLAGS;
			8'h9E: return tad_pkg::TAD_OP_FLAGS_FROM_HIGH_ACCUM;
			8'h37: return tad_pkg::TAD_OP_ASCII_ADJUST_ADD;
			8'h27: return tad_pkg::TAD_OP_DECIMAL_ADJUST_ADD;
			8'h3F: return tad_pkg::TAD_OP_ASCII_ADJUST_SUBTRACT;
			8'h2F: return tad_pkg::TAD_OP_DECIMAL_ADJUST_SUBTRACT;
			8'h98: return tad_pkg::TAD_OP_BYTE_TO_WORD_EXTEND;
			8'h99: return tad_pkg::TAD_OP_WORD_TO_DOUBLE_EXTEND;
			default: return tad_pkg::TAD_OP_NONE;
		endcase
	endfunction : single_op

	// ------------------------------
	// properties
	// ------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	ready_high_a: assert property (byte_ready_out == 1'b1)
		else $error("decoder stalled the byte stream");
	done_cause_a: assert property (done_out |-> $past(byte_valid_in))
		else $error("done without a byte taken the edge before");
	single_byte_a: assert property (
		at_op && byte_valid_in && single_op(byte_in) != tad_pkg::TAD_OP_NONE
		|=> done_out && !invalid_out && op_out == single_op($past(byte_in)))
		else $error("single byte opcode misclassified");
	modrm_wait_a: assert property (
		at_op && byte_valid_in && byte_in[7:2] inside {6'h00, 6'h04, 6'h0A, 6'h06} |=> !done_out)
		else $error("arithmetic form finished without its addressing byte");
	reg_form_a: assert property (
		at_op && byte_valid_in && byte_in[7:2] inside {6'h00, 6'h04, 6'h0A, 6'h06}
		##1 byte_valid_in && byte_in[7:6] == 2'h3 |=> done_out && word_out == first_q[0]
		&& dir_to_reg_out == first_q[1] && {mod_out, reg_out, rm_out} == $past(byte_in))
		else $error("direction, width or fields wrong");
	group_op_a: assert property (
		at_op && byte_valid_in && byte_in[7:1] == 7'h7B ##1 byte_valid_in && byte_in[7:5] == 3'h7
		|=> done_out && !invalid_out && word_out == first_q[0]
		&& {mod_out, reg_out, rm_out} == $past(byte_in)
		&& op_out == tad_pkg::tad_op_e'(5'(tad_pkg::TAD_OP_UNSIGNED_PRODUCT) + 5'(reg_out[1:0])))
		else $error("multiply or divide misclassified");
	seg_select_a: assert property (
		at_op && byte_valid_in && byte_in inside {8'h8E, 8'h8C}
		##1 byte_valid_in && byte_in[7:6] == 2'h3 && !byte_in[5] |=> done_out && !invalid_out
		&& op_out == (first_q[1] ? tad_pkg::TAD_OP_SEG_FROM_RM : tad_pkg::TAD_OP_SEG_TO_RM))
		else $error("segment transfer misclassified");
	fixed_second_a: assert property (
		at_op && byte_valid_in && byte_in inside {8'hD4, 8'hD5} ##1 byte_valid_in
		|=> done_out && invalid_out == ($past(byte_in) != 8'h0A))
		else $error("fixed second byte not checked");
	imm_word_a: assert property (
		at_op && byte_valid_in && byte_in == 8'h15 ##1 byte_valid_in ##1 byte_valid_in
		|=> done_out && imm_out == {$past(byte_in), $past(byte_in, 2)})
		else $error("word immediate wrong");
	imm_byte_a: assert property (
		at_op && byte_valid_in && byte_in == 8'h14 ##1 byte_valid_in
		|=> done_out && imm_out[7:0] == $past(byte_in))
		else $error("byte immediate wrong");

	cover property (done_out && invalid_out);
	cover property (done_out ##1 done_out);
	cover property (at_op && byte_valid_in && byte_in == 8'h81);
endmodule : tad_decoder_assertions

// >>> tb/tad_decoder_tb_top.sv
// testbench for the transfer and arithmetic opcode decoder
module tad_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic byte_valid_in;
	logic [7:0] byte_in;
	logic byte_ready_out;
	logic done_out;
	tad_pkg::tad_op_e op_out;
	logic word_out;
	logic dir_to_reg_out;
	logic [1:0] mod_out;
	logic [2:0] reg_out;
	logic [2:0] rm_out;
	logic [15:0] disp_out;
	logic [15:0] imm_out;
	logic invalid_out;
	int fails = 0;
	int samples_checked = 0;
	logic [7:0] fam [4] = '{8'h00, 8'h10, 8'h28, 8'h18};
	tad_pkg::tad_op_e fam_op [4] = '{tad_pkg::TAD_OP_ADD, tad_pkg::TAD_OP_ADD_WITH_CARRY,
		tad_pkg::TAD_OP_SUBTRACT, tad_pkg::TAD_OP_SUBTRACT_WITH_BORROW};
	logic [7:0] one [9] = '{8'hD7, 8'h9F, 8'h9E, 8'h37, 8'h27, 8'h3F, 8'h2F, 8'h98, 8'h99};
	tad_pkg::tad_op_e one_op [9] = '{tad_pkg::TAD_OP_TABLE_TRANSLATE_BYTE,
		tad_pkg::TAD_OP_HIGH_ACCUM_FROM_FLAGS, tad_pkg::TAD_OP_FLAGS_FROM_HIGH_ACCUM,
		tad_pkg::TAD_OP_ASCII_ADJUST_ADD, tad_pkg::TAD_OP_DECIMAL_ADJUST_ADD,
		tad_pkg::TAD_OP_ASCII_ADJUST_SUBTRACT, tad_pkg::TAD_OP_DECIMAL_ADJUST_SUBTRACT,
		tad_pkg::TAD_OP_BYTE_TO_WORD_EXTEND, tad_pkg::TAD_OP_WORD_TO_DOUBLE_EXTEND};
	tad_pkg::tad_op_e grp_op [4] = '{tad_pkg::TAD_OP_UNSIGNED_PRODUCT,
		tad_pkg::TAD_OP_SIGNED_PRODUCT, tad_pkg::TAD_OP_UNSIGNED_QUOTIENT,
		tad_pkg::TAD_OP_SIGNED_QUOTIENT};

	tad_fetch_model fetch (.clk_in(clk_in), .byte_valid_out(byte_valid_in), .byte_out(byte_in));
	tad_decoder uut (.clk_in, .reset_n_in, .byte_valid_in, .byte_in, .byte_ready_out, .done_out,
		.op_out, .word_out, .dir_to_reg_out, .mod_out, .reg_out, .rm_out, .disp_out, .imm_out,
		.invalid_out);

	initial forever #50 clk_in = ~clk_in;

	// ------------------------------
	// check and access tasks
	// ------------------------------
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp

	// bytes go low byte first; done is a one-cycle pulse right after the last byte is taken
	task automatic run(input logic [39:0] b, input int n, input int gap,
		input tad_pkg::tad_op_e op, input logic inv);
		for (int i = 0; i < n; i++) begin
			fetch.put(b[8*i +: 8], gap);
		end
		fetch.idle();
		#1;
		cmp(16'(done_out), 16'h0001, "done");
		cmp(16'(op_out), 16'(op), "class");
		cmp(16'(invalid_out), 16'(inv), "invalid");
	endtask : run

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		run(40'h00_0000_C88E, 2, 0, tad_pkg::TAD_OP_SEG_FROM_RM, 1'b0);
		cmp(16'(reg_out), 16'h0001, "segment selector");
		run(40'h00_0000_E88E, 2, 0, tad_pkg::TAD_OP_INVALID, 1'b1);
		run(40'h00_0000_D88C, 2, 1, tad_pkg::TAD_OP_SEG_TO_RM, 1'b0);
		run(40'h00_0010_468D, 3, 0, tad_pkg::TAD_OP_LOAD_EFFECTIVE_ADDRESS, 1'b0);
		cmp(disp_out, 16'h0010, "short displacement");
		run(40'h00_1234_06C5, 4, 1, tad_pkg::TAD_OP_FAR_POINTER_LOAD_DATA_SEG, 1'b0);
		cmp(disp_out, 16'h1234, "direct address");
		run(40'h00_FFFE_86C4, 4, 0, tad_pkg::TAD_OP_FAR_POINTER_LOAD_EXTRA_SEG, 1'b0);
		cmp(disp_out, 16'hFFFE, "word displacement");
		for (int s = 0; s < 9; s++) begin
			run({32'h0000_0000, one[s]}, 1, s % 2, one_op[s], 1'b0);
		end
		// back to back, the first finishes while the second is taken
		fetch.put(8'h9F, 0);
		run(40'h00_0000_009E, 1, 0, tad_pkg::TAD_OP_FLAGS_FROM_HIGH_ACCUM, 1'b0);
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 4; k++) begin
				run({32'h0000_00C3, fam[f] + 8'(k)}, 2, 0, fam_op[f], 1'b0);
				cmp(16'({dir_to_reg_out, word_out}), 16'(k), "d and w");
			end
		end
		for (int m = 0; m < 8; m++) begin
			run({24'h00_0000, 2'h3, 1'b1, m[2:1], 3'h1, 7'h7B, m[0]}, 2, 0, grp_op[m[2:1]],
				1'b0);
			cmp(16'(word_out), 16'(m[0]), "width");
		end
		run(40'h00_0000_0AD4, 2, 1, tad_pkg::TAD_OP_ASCII_ADJUST_MULTIPLY, 1'b0);
		run(40'h00_0000_0AD5, 2, 0, tad_pkg::TAD_OP_ASCII_ADJUST_DIVIDE, 1'b0);
		run(40'h00_0000_0BD4, 2, 0, tad_pkg::TAD_OP_INVALID, 1'b1);
		run(40'h00_0000_C0F7, 2, 0, tad_pkg::TAD_OP_INVALID, 1'b1);
		run(40'h00_0000_7F14, 2, 2, tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_ACC, 1'b0);
		cmp(16'(imm_out[7:0]), 16'h007F, "byte immediate");
		// back to back bytes so the byte immediate property sees this one
		run(40'h00_0000_8014, 2, 0, tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_ACC, 1'b0);
		cmp(imm_out, 16'h0080, "zero extended immediate");
		run(40'h00_0012_3415, 3, 0, tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_ACC, 1'b0);
		cmp(imm_out, 16'h1234, "word immediate");
		run(40'h00_FF10_4683, 4, 0, tad_pkg::TAD_OP_ADD_IMM_RM, 1'b0);
		cmp(imm_out, 16'hFFFF, "extended immediate");
		cmp(disp_out, 16'h0010, "displacement ahead of data");
		run(40'h56_7810_4681, 5, 0, tad_pkg::TAD_OP_ADD_IMM_RM, 1'b0);
		cmp(imm_out, 16'h5678, "two immediate bytes");
		run(40'h00_0080_D083, 3, 0, tad_pkg::TAD_OP_ADD_WITH_CARRY_IMM_RM, 1'b0);
		cmp(imm_out, 16'hFF80, "sign extended immediate");
		run(40'h00_0080_E883, 3, 0, tad_pkg::TAD_OP_SUBTRACT_IMM_RM, 1'b0);
		run(40'h00_0080_D883, 3, 1, tad_pkg::TAD_OP_SUBTRACT_WITH_BORROW_IMM_RM,
			1'b0);
		run(40'h00_0080_C883, 3, 0, tad_pkg::TAD_OP_INVALID, 1'b1);
		// reset in mid-instruction must drop the half-taken opcode
		fetch.put(8'h00, 0);
		fetch.idle();
		reset_n_in <= 1'b0;
		@(posedge clk_in);
		reset_n_in <= 1'b1;
		#1;
		cmp(16'({done_out, invalid_out}), 16'h0000, "flags after reset");
		cmp(16'(op_out), 16'(tad_pkg::TAD_OP_NONE), "class after reset");
		run(40'h00_0000_00D7, 1, 0, tad_pkg::TAD_OP_TABLE_TRANSLATE_BYTE, 1'b0);
		run(40'h00_0000_00D6, 1, 0, tad_pkg::TAD_OP_INVALID, 1'b1);
		print_verdict();
	end

	initial begin
		#2_000_000;
		fails++;
		print_verdict();
	end
endmodule : tad_decoder_tb_top

bind tad_decoder tad_decoder_assertions chk (.clk_in, .reset_n_in, .byte_valid_in, .byte_in,
	.byte_ready_out, .done_out, .op_out, .word_out, .dir_to_reg_out, .mod_out, .reg_out, .rm_out,
	.imm_out, .invalid_out);
